// ### logic/mposs_main_power_off.sv
// Overview of operation
// - On main AC loss the reaction select picks hold, fault reaction, shutdown or quick stop.
// - Reaction 0 suppresses the profile deceleration on power loss in favour of the drive's own.
// - Profile deceleration stays in effect until main AC loss is declared only for reactions 1 to 3 with a nonzero option.
// - A DC bus undervoltage raises the bus undervoltage error first and stops by the alarm sequence.
// - The detection time is accepted from 20 to 2000 ms.
// - The power loss sequence (0 to 9) applies once detection elapses with trip bit0 at 0 (except reaction 1, option 0) or reaction 2 or 3 with option 0.
// - The power loss sequence sets the motor state while decelerating and after the stop.
// - A detection time of 2000 disables main AC loss detection.
// - With trip bit0 at 1 an elapsed detection time raises the trip error and the alarm stop under reaction 0, or reactions 1 to 3 with a nonzero option.
// - The low voltage trip select takes 0 to 3 and chooses trip, deceleration or warning.
`timescale 1ns/1ps
`default_nettype none
module mposs_main_power_off
    import mposs_pkg::*;
#(
    parameter int CYC_MS = CYC_PER_MS
) (
    input  wire logic        CORE_CLK,        // Control clock, 10 MHz
    input  wire logic        RESET_N,         // Asynchronous reset
    input  wire logic        OBJ_WR,          // Object write strobe
    input  wire logic        OBJ_RD,          // Object read strobe
    input  wire mposs_obj_s  OBJ_REQ,         // Index and write data
    output logic [31:0]      OBJ_RDATA,       // Read data
    output logic             OBJ_ACK,         // Access done pulse
    output logic             OBJ_REFUSED,     // Access refused pulse
    input  wire logic [15:0] FAULT_OPT,       // Fault reaction select
    input  wire logic [15:0] SHUTDOWN_OPT,    // Shutdown reaction select
    input  wire logic [15:0] QSTOP_OPT,       // Emergency stop reaction select
    input  wire logic        MAIN_AC_PRESENT, // Main AC pin
    input  wire logic        BUS_UNDERVOLT,   // DC bus low pin
    input  wire logic        DECEL_DONE,      // Motor stopped
    input  wire logic        ERR_CLEAR,       // Error reset
    output mposs_src_e       DECEL_SOURCE,    // Active deceleration source
    output logic [3:0]       STOP_SEQ,        // Drive-side sequence value
    output logic             PROFILE_EN,      // Profile deceleration allowed
    output logic             POWER_OFF,       // Main power off declared
    output logic             POWER_WARN,      // Main power off warning
    output mposs_err_s       ERRORS           // Latched errors
);

    // ------------------------------------------------------------
    // Object storage
    // ------------------------------------------------------------
    logic [15:0] servo_off_seq;
    logic [15:0] loss_seq;
    logic [15:0] lv_trip;
    logic [15:0] detect_time;
    logic [15:0] alarm_seq;
    logic [15:0] reaction;
    logic [31:0] rate_mem [5];

    wire hit_soff  = OBJ_REQ.index == IDX_SERVO_OFF_SEQ;
    wire hit_loss  = OBJ_REQ.index == IDX_LOSS_SEQ;
    wire hit_lv    = OBJ_REQ.index == IDX_LV_TRIP_SEL;
    wire hit_det   = OBJ_REQ.index == IDX_DETECT_TIME;
    wire hit_alarm = OBJ_REQ.index == IDX_ALARM_SEQ;
    wire hit_react = OBJ_REQ.index == IDX_LINK_LOSS_SEL;
    wire [15:0] wd = OBJ_REQ.data[15:0];
    wire hi_zero   = OBJ_REQ.data[31:16] == 16'h0000;

    logic [2:0] rate_idx;
    logic       hit_rate;
    always_comb
    begin
        hit_rate = 1'b1;
        rate_idx = 3'h0;
        if (OBJ_REQ.index == IDX_PROFILE_DECEL)
            rate_idx = 3'h0;
        else if (OBJ_REQ.index == IDX_EMERG_DECEL)
            rate_idx = 3'h1;
        else if (OBJ_REQ.index == IDX_TORQUE_RAMP)
            rate_idx = 3'h2;
        else if (OBJ_REQ.index == IDX_HOMING_ACCEL)
            rate_idx = 3'h3;
        else if (OBJ_REQ.index == IDX_UPPER_DECEL)
            rate_idx = 3'h4;
        else
            hit_rate = 1'b0;
    end

    // Out-of-range values are refused so the sequencer never sees them
    wire ok_soff  = hit_soff  && hi_zero && wd <= SEQ_MAX;
    wire ok_loss  = hit_loss  && hi_zero && wd <= SEQ_MAX;
    wire ok_lv    = hit_lv    && hi_zero && wd <= LV_TRIP_MAX;
    wire ok_det   = hit_det   && hi_zero && wd >= DETECT_MIN
                    && wd <= DETECT_MAX;
    wire ok_alarm = hit_alarm && hi_zero && wd <= ALARM_SEQ_MAX;
    wire ok_react = hit_react && hi_zero && wd <= REACTION_MAX;
    wire wr_ok    = ok_soff | ok_loss | ok_lv | ok_det | ok_alarm | ok_react | hit_rate;
    wire rd_hit   = hit_soff | hit_loss | hit_lv | hit_det | hit_alarm | hit_react | hit_rate;

    logic [31:0] rd_val;
    always_comb
    begin
        rd_val = 32'h0000_0000;
        if (hit_soff)
            rd_val = {16'h0000, servo_off_seq};
        else if (hit_loss)
            rd_val = {16'h0000, loss_seq};
        else if (hit_lv)
            rd_val = {16'h0000, lv_trip};
        else if (hit_det)
            rd_val = {16'h0000, detect_time};
        else if (hit_alarm)
            rd_val = {16'h0000, alarm_seq};
        else if (hit_react)
            rd_val = {16'h0000, reaction};
        else if (hit_rate)
            rd_val = rate_mem[rate_idx];
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            servo_off_seq <= DEF_SEQ;
            loss_seq      <= DEF_SEQ;
            lv_trip       <= DEF_LV_TRIP;
            detect_time   <= DEF_DETECT;
            alarm_seq     <= DEF_SEQ;
            reaction      <= DEF_REACTION;
            for (int i = 0; i < 5; i++)
                rate_mem[i] <= DEF_RATE;
        end
        else if (OBJ_WR)
        begin
            if (ok_soff)  servo_off_seq <= wd;
            if (ok_loss)  loss_seq      <= wd;
            if (ok_lv)    lv_trip       <= wd;
            if (ok_det)   detect_time   <= wd;
            if (ok_alarm) alarm_seq     <= wd;
            if (ok_react) reaction      <= wd;
            if (hit_rate) rate_mem[rate_idx] <= OBJ_REQ.data;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            OBJ_RDATA   <= 32'h0000_0000;
            OBJ_ACK     <= 1'b0;
            OBJ_REFUSED <= 1'b0;
        end
        else
        begin
            OBJ_RDATA   <= (OBJ_RD && rd_hit) ? rd_val : OBJ_RDATA;
            OBJ_ACK     <= (OBJ_WR && wr_ok) || (OBJ_RD && rd_hit);
            OBJ_REFUSED <= (OBJ_WR && !wr_ok) || (OBJ_RD && !rd_hit);
        end
    end

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] ac_sync;
    logic [2:0] uv_sync;
    logic       ac_ok;
    logic       pn_low;
    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            ac_sync <= 3'h7;
            uv_sync <= 3'h0;
            ac_ok   <= 1'b1;
            pn_low  <= 1'b0;
        end
        else
        begin
            ac_sync <= {ac_sync[1:0], MAIN_AC_PRESENT};
            uv_sync <= {uv_sync[1:0], BUS_UNDERVOLT};
            ac_ok   <= (ac_sync[1] == ac_sync[2]) ? ac_sync[2] : ac_ok;
            pn_low  <= (uv_sync[1] == uv_sync[2]) ? uv_sync[2] : pn_low;
        end
    end
    wire ac_lost = !ac_ok;

    // ------------------------------------------------------------
    // Absence timer
    // ------------------------------------------------------------
    localparam int PW = $clog2(CYC_MS);
    logic [PW-1:0] pre_cnt;
    logic [15:0]   ms_cnt;
    wire ms_tick      = pre_cnt == PW'(CYC_MS - 1);
    wire detect_on    = detect_time != DETECT_MAX;
    wire declared     = ac_lost && detect_on && ms_cnt >= detect_time;

    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            pre_cnt <= '0;
            ms_cnt  <= 16'h0000;
        end
        else if (!ac_lost)
        begin
            pre_cnt <= '0;
            ms_cnt  <= 16'h0000;
        end
        else
        begin
            pre_cnt <= ms_tick ? '0 : pre_cnt + PW'(1);
            if (ms_tick && ms_cnt < DETECT_MAX)
                ms_cnt <= ms_cnt + 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // Reaction selection
    // ------------------------------------------------------------
    wire trip_sel   = lv_trip[LV_TRIP_BIT];
    wire fault_zero = FAULT_OPT == OPT_STOP_SEQ;
    wire alarm_held = ERRORS.bus_uv || ERRORS.trip || (ERRORS.fault && fault_zero);

    mposs_src_e next_src;
    logic       set_uv;
    logic       set_trip;
    logic       set_fault;
    always_comb
    begin
        next_src  = SRC_PROFILE;
        set_uv    = 1'b0;
        set_trip  = 1'b0;
        set_fault = ac_lost && reaction == REACT_FAULT && DECEL_DONE
                    && DECEL_SOURCE != SRC_PROFILE;
        if (pn_low)
        begin
            set_uv   = 1'b1;
            next_src = SRC_ALARM;
        end
        else if (alarm_held)
            next_src = SRC_ALARM;
        else if (ac_lost)
        begin
            case (reaction)
                REACT_NONE:
                    if (declared)
                    begin
                        set_trip = trip_sel;
                        next_src = trip_sel ? SRC_ALARM : SRC_LOSS;
                    end
                REACT_FAULT:
                    if (fault_zero)
                    begin
                        set_fault = 1'b1;
                        next_src  = SRC_ALARM;
                    end
                    else if (declared)
                    begin
                        set_trip = trip_sel;
                        next_src = trip_sel ? SRC_ALARM : SRC_LOSS;
                    end
                    else
                        next_src = SRC_FAULT;
                REACT_SHUTDOWN:
                    if (declared && (SHUTDOWN_OPT == OPT_STOP_SEQ || !trip_sel))
                        next_src = SRC_LOSS;
                    else if (declared)
                    begin
                        set_trip = 1'b1;
                        next_src = SRC_ALARM;
                    end
                    else
                        next_src = (SHUTDOWN_OPT == OPT_STOP_SEQ) ? SRC_SERVOOFF
                                                                  : SRC_SHUTDOWN;
                default:
                    if (declared && (QSTOP_OPT == OPT_STOP_SEQ || !trip_sel))
                        next_src = SRC_LOSS;
                    else if (declared)
                    begin
                        set_trip = 1'b1;
                        next_src = SRC_ALARM;
                    end
                    else
                        next_src = (QSTOP_OPT == OPT_STOP_SEQ) ? SRC_SERVOOFF
                                                               : SRC_QSTOP;
            endcase
        end
    end

    logic [3:0] next_seq;
    always_comb
    begin
        case (next_src)
            SRC_SERVOOFF: next_seq = servo_off_seq[3:0];
            SRC_LOSS:     next_seq = loss_seq[3:0];
            SRC_ALARM:    next_seq = alarm_seq[3:0];
            default:      next_seq = 4'h0;
        endcase
    end

    // Profile decel is withheld once the drive side owns the stop
    wire next_profile_en = !declared && !(ac_lost && reaction == REACT_NONE)
                           && (next_src == SRC_PROFILE || next_src == SRC_FAULT
                           || next_src == SRC_SHUTDOWN || next_src == SRC_QSTOP);

    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            DECEL_SOURCE <= SRC_PROFILE;
            STOP_SEQ     <= 4'h0;
            PROFILE_EN   <= 1'b1;
            POWER_OFF    <= 1'b0;
            POWER_WARN   <= 1'b0;
            ERRORS       <= '0;
        end
        else
        begin
            DECEL_SOURCE  <= next_src;
            STOP_SEQ      <= next_seq;
            PROFILE_EN    <= next_profile_en;
            POWER_OFF     <= declared;
            POWER_WARN    <= declared && lv_trip[LV_WARN_BIT];
            // A new event in the clear cycle keeps its flag
            ERRORS.bus_uv <= set_uv    || (ERRORS.bus_uv && !ERR_CLEAR);
            ERRORS.trip   <= set_trip  || (ERRORS.trip   && !ERR_CLEAR);
            ERRORS.fault  <= set_fault || (ERRORS.fault  && !ERR_CLEAR);
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_uv_seen;
        pn_low;
    endsequence
    sequence s_alarm_stop;
        ERRORS.bus_uv && DECEL_SOURCE == SRC_ALARM && STOP_SEQ == alarm_seq[3:0];
    endsequence

    uv_alarm_stop_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        s_uv_seen |=> s_alarm_stop)
        else $error("bus undervoltage did not force alarm stop");

    detect_disabled_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        detect_time == DETECT_MAX |=> !POWER_OFF)
        else $error("loss declared with detection disabled");

    declare_time_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        $rose(POWER_OFF) |-> $past(ms_cnt) == $past(detect_time))
        else $error("loss declared at wrong millisecond count");

    timer_restart_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        ac_ok |=> ms_cnt == 16'h0000 && !POWER_OFF)
        else $error("absence timer not restarted on AC return");

    detect_range_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        OBJ_WR && hit_det && (wd < DETECT_MIN || wd > DETECT_MAX)
        |=> $stable(detect_time) ##0 OBJ_REFUSED)
        else $error("out of range detection time accepted");

    hold_state_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        ac_lost && reaction == REACT_NONE && !declared && !pn_low && !alarm_held
        |=> DECEL_SOURCE == SRC_PROFILE && !PROFILE_EN)
        else $error("hold on power loss not kept");

    loss_seq_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        declared && !trip_sel && !pn_low && !alarm_held && reaction != REACT_FAULT
        |=> DECEL_SOURCE == SRC_LOSS && STOP_SEQ == $past(loss_seq[3:0]))
        else $error("power loss sequence not applied");

    trip_error_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        declared && trip_sel && reaction == REACT_NONE && !pn_low
        |=> ERRORS.trip && DECEL_SOURCE == SRC_ALARM)
        else $error("trip error not raised after detection time");

    qstop_pick_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        ac_lost && !declared && reaction == REACT_QSTOP && QSTOP_OPT != OPT_STOP_SEQ
        && !pn_low && !alarm_held |=> DECEL_SOURCE == SRC_QSTOP && PROFILE_EN)
        else $error("quick stop reaction not selected");

    profile_kept_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        ac_ok && !pn_low && !alarm_held |=> PROFILE_EN && DECEL_SOURCE == SRC_PROFILE)
        else $error("profile deceleration dropped without power loss");

endmodule : mposs_main_power_off
`default_nettype wire

// ### logic/mposs_pkg.sv
package mposs_pkg;

    // ------------------------------------------------------------
    // Object indices
    // ------------------------------------------------------------
    localparam logic [15:0] IDX_SERVO_OFF_SEQ  = 16'h3506;
    localparam logic [15:0] IDX_LOSS_SEQ       = 16'h3507;
    localparam logic [15:0] IDX_LV_TRIP_SEL    = 16'h3508;
    localparam logic [15:0] IDX_DETECT_TIME    = 16'h3509;
    localparam logic [15:0] IDX_ALARM_SEQ      = 16'h3510;
    localparam logic [15:0] IDX_LINK_LOSS_SEL  = 16'h6007;
    localparam logic [15:0] IDX_PROFILE_DECEL  = 16'h6084;
    localparam logic [15:0] IDX_EMERG_DECEL    = 16'h6085;
    localparam logic [15:0] IDX_TORQUE_RAMP    = 16'h6087;
    localparam logic [15:0] IDX_HOMING_ACCEL   = 16'h609a;
    localparam logic [15:0] IDX_UPPER_DECEL    = 16'h60c6;

    // ------------------------------------------------------------
    // Ranges
    // ------------------------------------------------------------
    localparam logic [15:0] REACTION_MAX  = 16'h0003;
    localparam logic [15:0] SEQ_MAX       = 16'h0009;
    localparam logic [15:0] ALARM_SEQ_MAX = 16'h0007;
    localparam logic [15:0] LV_TRIP_MAX   = 16'h0003;
    localparam logic [15:0] DETECT_MIN    = 16'h0014;
    localparam logic [15:0] DETECT_MAX    = 16'h07d0;
    localparam logic [15:0] OPT_STOP_SEQ  = 16'h0000;

    localparam int LV_TRIP_BIT = 0;
    localparam int LV_WARN_BIT = 1;

    localparam logic [15:0] REACT_NONE     = 16'h0000;
    localparam logic [15:0] REACT_FAULT    = 16'h0001;
    localparam logic [15:0] REACT_SHUTDOWN = 16'h0002;
    localparam logic [15:0] REACT_QSTOP    = 16'h0003;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] DEF_REACTION = 16'h0000;
    localparam logic [15:0] DEF_SEQ      = 16'h0000;
    localparam logic [15:0] DEF_LV_TRIP  = 16'h0000;
    localparam logic [15:0] DEF_DETECT   = 16'h0046;
    localparam logic [31:0] DEF_RATE     = 32'h0000_0000;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int MS_NS         = 1000000;
    localparam int CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        SRC_PROFILE  = 3'h0,
        SRC_FAULT    = 3'h1,
        SRC_SHUTDOWN = 3'h2,
        SRC_QSTOP    = 3'h3,
        SRC_SERVOOFF = 3'h4,
        SRC_LOSS     = 3'h5,
        SRC_ALARM    = 3'h6
    } mposs_src_e;

    typedef struct packed {
        logic [15:0] index;
        logic [31:0] data;
    } mposs_obj_s;

    typedef struct packed {
        logic bus_uv;
        logic trip;
        logic fault;
    } mposs_err_s;

endpackage : mposs_pkg

// ### sim/mposs_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module mposs_master_model
    import mposs_pkg::*;
(
    input  wire logic        CORE_CLK,   // Control clock
    output logic             OBJ_WR,     // Write strobe
    output logic             OBJ_RD,     // Read strobe
    output mposs_obj_s       OBJ_REQ,    // Index and data
    input  wire logic [31:0] OBJ_RDATA,  // Read data
    input  wire logic        OBJ_ACK,    // Accepted
    input  wire logic        OBJ_REFUSED // Refused
);
    initial
    begin
        OBJ_WR  = 1'b0;
        OBJ_RD  = 1'b0;
        OBJ_REQ = '0;
    end

    // Resp: 0 accepted, 1 refused, 2 no answer
    task automatic access(input logic wr, input logic [15:0] idx, input logic [31:0] dat,
                          output logic [31:0] rdat, output int resp);
        int n;
        n    = 0;
        resp = 2;
        rdat = 32'h0;
        // A master never offers a reaction code above 3
        if (wr && idx == IDX_LINK_LOSS_SEL && dat > {16'h0, REACTION_MAX})
        begin
            resp = 1;
            return;
        end
        @(negedge CORE_CLK);
        OBJ_WR  = wr;
        OBJ_RD  = !wr;
        OBJ_REQ = '{idx, dat};
        // Strobe is one cycle per access; a longer one would be a second access
        @(negedge CORE_CLK);
        OBJ_WR  = 1'b0;
        OBJ_RD  = 1'b0;
        OBJ_REQ = ~OBJ_REQ;
        while (resp == 2 && n < 4)
        begin
            if (OBJ_ACK === 1'b1)
            begin
                resp = 0;
                rdat = OBJ_RDATA;
            end
            else if (OBJ_REFUSED === 1'b1)
                resp = 1;
            else
                @(negedge CORE_CLK);
            n++;
        end
    endtask : access
endmodule : mposs_master_model
`default_nettype wire

// ### sim/test_mposs_main_power_off.sv
`timescale 1ns/1ps
`default_nettype none
module test_mposs_main_power_off;
    import mposs_pkg::*;
    logic clk, rst_n, wr_s, rd_s, ac, uv, ddone, eclr, ack, refd, pen, poff, pwarn;
    logic [15:0] fopt, sopt, qopt;
    logic [31:0] rdat;
    logic [3:0]  seq;
    mposs_obj_s  req;
    mposs_src_e  src;
    mposs_err_s  errs;
    int          n_mismatch, cmp_count, n;

    mposs_main_power_off #(.CYC_MS(4)) i_dut (.CORE_CLK(clk), .RESET_N(rst_n),
        .OBJ_WR(wr_s), .OBJ_RD(rd_s), .OBJ_REQ(req), .OBJ_RDATA(rdat), .OBJ_ACK(ack),
        .OBJ_REFUSED(refd), .FAULT_OPT(fopt), .SHUTDOWN_OPT(sopt), .QSTOP_OPT(qopt),
        .MAIN_AC_PRESENT(ac), .BUS_UNDERVOLT(uv), .DECEL_DONE(ddone), .ERR_CLEAR(eclr),
        .DECEL_SOURCE(src), .STOP_SEQ(seq), .PROFILE_EN(pen), .POWER_OFF(poff),
        .POWER_WARN(pwarn), .ERRORS(errs));
    mposs_master_model i_master (.CORE_CLK(clk), .OBJ_WR(wr_s), .OBJ_RD(rd_s),
        .OBJ_REQ(req), .OBJ_RDATA(rdat), .OBJ_ACK(ack), .OBJ_REFUSED(refd));

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic acc(input logic w, input logic [15:0] idx, input logic [31:0] d,
                       input int exp_resp, input logic [31:0] exp_d);
        logic [31:0] r;
        int          resp;
        i_master.access(w, idx, d, r, resp);
        if (resp == 2)
        begin
            n_mismatch++;
            $display("FAIL answer expected ack seen none");
            end_sim();
        end
        chk("response", resp, exp_resp);
        if (!w && exp_resp == 0)
            chk("read data", r, exp_d);
    endtask : acc

    task automatic do_reset();
        rst_n = 1'b0;
        ac    = 1'b1;
        uv    = 1'b0;
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
    endtask : do_reset

    // Counts cycles until power off is declared, giving up at the limit
    task automatic wait_off(input int lim);
        n = 0;
        while (poff !== 1'b1 && n < lim)
        begin
            @(negedge clk);
            n++;
        end
        if (poff !== 1'b1)
        begin
            n_mismatch++;
            $display("FAIL power off expected 1 seen 0");
            end_sim();
        end
    endtask : wait_off

    logic [15:0] bad_idx [6] = '{IDX_DETECT_TIME, IDX_DETECT_TIME, IDX_LV_TRIP_SEL,
                                 IDX_LOSS_SEQ, IDX_ALARM_SEQ, 16'h1234};
    logic [31:0] bad_val [6] = '{32'h13, 32'h7d1, 32'h4, 32'ha, 32'h8, 32'h0};
    logic [15:0] r_tab [5] = '{16'h0, 16'h1, 16'h2, 16'h3, 16'h2};
    logic [15:0] s_tab [5] = '{16'h1, 16'h1, 16'h1, 16'h1, 16'h0};
    mposs_src_e  e_tab [5] = '{SRC_PROFILE, SRC_FAULT, SRC_SHUTDOWN, SRC_QSTOP, SRC_SERVOOFF};

    initial
    begin
        {ddone, eclr} = '0;
        {n_mismatch, cmp_count} = '0;
        {fopt, qopt} = {16'h1, 16'h1};
        sopt = 16'h1;
        do_reset();
        // ------------------------------------------------------------
        // Objects: defaults, range, refusals
        // ------------------------------------------------------------
        acc(1'b0, IDX_DETECT_TIME, 32'h0, 0, 32'h46);
        acc(1'b0, IDX_LINK_LOSS_SEL, 32'h0, 0, 32'h0);
        acc(1'b1, IDX_PROFILE_DECEL, 32'h1234_5678, 0, 32'h0);
        acc(1'b0, IDX_PROFILE_DECEL, 32'h0, 0, 32'h1234_5678);
        for (int i = 0; i < 6; i++)
            acc(1'b1, bad_idx[i], bad_val[i], 1, 32'h0);
        acc(1'b1, IDX_LV_TRIP_SEL, 32'h1_0001, 1, 32'h0);
        acc(1'b0, IDX_DETECT_TIME, 32'h0, 0, 32'h46);
        acc(1'b1, IDX_DETECT_TIME, 32'h7d0, 0, 32'h0);
        acc(1'b1, IDX_DETECT_TIME, 32'h14, 0, 32'h0);
        // ------------------------------------------------------------
        // Drive-side power loss sequence, count restart on AC return
        // ------------------------------------------------------------
        acc(1'b1, IDX_LOSS_SEQ, 32'h9, 0, 32'h0);
        acc(1'b1, IDX_LV_TRIP_SEL, 32'h2, 0, 32'h0);
        chk("profile_en", pen, 1'b1);
        ac = 1'b0;
        repeat (60) @(negedge clk);
        // Reaction 0 holds the state and keeps the profile ramp out
        chk("profile_en", pen, 1'b0);
        chk("hold source", src, SRC_PROFILE);
        ac = 1'b1;
        repeat (10) @(negedge clk);
        ac = 1'b0;
        wait_off(120);
        chk("off time", (n >= 81 && n <= 89), 1'b1);
        @(negedge clk);
        chk("source", src, SRC_LOSS);
        chk("stop seq", seq, 4'h9);
        chk("profile_en", pen, 1'b0);
        chk("warn", pwarn, 1'b1);
        // ------------------------------------------------------------
        // Trip bit set: trip error and alarm sequence
        // ------------------------------------------------------------
        do_reset();
        acc(1'b1, IDX_DETECT_TIME, 32'h14, 0, 32'h0);
        acc(1'b1, IDX_LV_TRIP_SEL, 32'h1, 0, 32'h0);
        acc(1'b1, IDX_ALARM_SEQ, 32'h7, 0, 32'h0);
        ac = 1'b0;
        wait_off(120);
        repeat (2) @(negedge clk);
        chk("trip err", errs.trip, 1'b1);
        chk("source", src, SRC_ALARM);
        chk("stop seq", seq, 4'h7);
        chk("warn", pwarn, 1'b0);
        // ------------------------------------------------------------
        // Detection disabled: reaction table on AC loss
        // ------------------------------------------------------------
        for (int i = 0; i < 5; i++)
        begin
            do_reset();
            sopt = s_tab[i];
            acc(1'b1, IDX_DETECT_TIME, 32'h7d0, 0, 32'h0);
            acc(1'b1, IDX_LINK_LOSS_SEL, {16'h0, r_tab[i]}, 0, 32'h0);
            ac = 1'b0;
            repeat (10) @(negedge clk);
            chk("reaction source", src, e_tab[i]);
        end
        // Fault reaction: error after the stop, alarm stop with option 0
        do_reset();
        acc(1'b1, IDX_DETECT_TIME, 32'h7d0, 0, 32'h0);
        acc(1'b1, IDX_LINK_LOSS_SEL, 32'h1, 0, 32'h0);
        ac = 1'b0;
        repeat (10) @(negedge clk);
        chk("source", src, SRC_FAULT);
        ddone = 1'b1;
        repeat (2) @(negedge clk);
        chk("fault err", errs.fault, 1'b1);
        {ddone, eclr, ac} = 3'h3;
        repeat (10) @(negedge clk);
        chk("fault err", errs.fault, 1'b0);
        {fopt, eclr, ac} = {16'h0, 2'h0};
        repeat (10) @(negedge clk);
        chk("fault err", errs.fault, 1'b1);
        chk("source", src, SRC_ALARM);
        do_reset();
        acc(1'b1, IDX_DETECT_TIME, 32'h7d0, 0, 32'h0);
        ac = 1'b0;
        repeat (8200) @(negedge clk);
        chk("power off", poff, 1'b0);
        // ------------------------------------------------------------
        // Bus undervoltage overrides
        // ------------------------------------------------------------
        uv = 1'b1;
        repeat (8) @(negedge clk);
        chk("bus uv err", errs.bus_uv, 1'b1);
        chk("source", src, SRC_ALARM);
        end_sim();
    end
endmodule : test_mposs_main_power_off
`default_nettype wire
